// ---- core/fgt_regs.sv ----
// Fine gain trim register bank with fuse defaults and per-core trim outputs
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module fgt_regs
	import fgt_pkg::*;
(
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  reset_n,
	input  wire logic                  clk_en,
	// Register port
	input  wire fgt_bus_req_type       bus_req,
	output      logic [FGT_DATA_W-1:0] rd_data_q,
	// Fuse storage
	output      fgt_fuse_req_type      fuse_req,
	input  wire logic [FGT_DATA_W-1:0] fuse_rd_data,
	input  wire logic                  fuse_reload,
	output      logic                  fuse_busy_q,
	// Analog input selection for cores 2 and 3
	input  wire logic                  core2_sel_second,
	input  wire logic                  core3_sel_second,
	// Trims to the converter cores
	output      logic [FGT_TRIM_W-1:0] core1_trim_q,
	output      logic [FGT_TRIM_W-1:0] core2_trim_q,
	output      logic [FGT_TRIM_W-1:0] core3_trim_q,
	output      logic [FGT_TRIM_W-1:0] core4_trim_q,
	output      logic [FGT_TRIM_W-1:0] core5_trim_q
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [FGT_DATA_W-1:0] regs_q [FGT_NUM_REGS];
	fgt_load_wr_type       load_wr;
	fgt_decode_type        wr_dec;
	fgt_decode_type        rd_dec;
	logic                  bus_wr_hit;
	logic                  bus_rd_hit;
	logic                  load_busy;
	logic [FGT_DATA_W-1:0] rd_data_d;

	////////////////////////////////////////////////////////////////////////
	// Fuse loader
	fgt_fuse_loader i_fgt_fuse_loader (
		.core_clk     (core_clk),
		.reset_n      (reset_n),
		.clk_en       (clk_en),
		.reload       (fuse_reload),
		.busy         (load_busy),
		.fuse_req     (fuse_req),
		.fuse_rd_data (fuse_rd_data),
		.load_wr_q    (load_wr)
	);

	////////////////////////////////////////////////////////////////////////
	// Address decode
	always_comb begin
		wr_dec     = fgt_decode(bus_req.addr);
		rd_dec     = fgt_decode(bus_req.addr);
		bus_wr_hit = bus_req.wr && wr_dec.hit;
		bus_rd_hit = bus_req.rd && rd_dec.hit;
	end

	////////////////////////////////////////////////////////////////////////
	// Register storage; a bus write beats a fuse word in the same cycle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < FGT_NUM_REGS; i++) begin
				regs_q[i] <= FGT_REG_RESET;
			end
		end else if (clk_en) begin
			for (int i = 0; i < FGT_NUM_REGS; i++) begin
				if (bus_wr_hit && (wr_dec.idx == FGT_IDX_W'(i))) begin
					regs_q[i] <= bus_req.wdata; // [RULE10]
				end else if (load_wr.valid && (load_wr.idx == FGT_IDX_W'(i))) begin
					regs_q[i] <= load_wr.data; // [RULE8]
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path: all eight bits, reserved ones included
	always_comb begin
		rd_data_d = FGT_REG_RESET;
		if (bus_rd_hit) begin
			rd_data_d = regs_q[rd_dec.idx]; // [RULE10]
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_q <= FGT_REG_RESET;
		end else if (clk_en) begin
			rd_data_q <= rd_data_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Loader status
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			fuse_busy_q <= 1'b1;
		end else if (clk_en) begin
			fuse_busy_q <= load_busy;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core 1 trim
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			core1_trim_q <= FGT_TRIM_RESET;
		end else if (clk_en) begin
			core1_trim_q <= fgt_trim(regs_q[FGT_IDX_CORE1]); // [RULE1]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core 2 trim follows its selected input
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			core2_trim_q <= FGT_TRIM_RESET;
		end else if (clk_en) begin
			if (core2_sel_second) begin
				core2_trim_q <= fgt_trim(regs_q[FGT_IDX_CORE2_B]); // [RULE3]
			end else begin
				core2_trim_q <= fgt_trim(regs_q[FGT_IDX_CORE2_A]); // [RULE2]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core 3 trim follows its selected input
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			core3_trim_q <= FGT_TRIM_RESET;
		end else if (clk_en) begin
			if (core3_sel_second) begin
				core3_trim_q <= fgt_trim(regs_q[FGT_IDX_CORE3_B]); // [RULE5]
			end else begin
				core3_trim_q <= fgt_trim(regs_q[FGT_IDX_CORE3_A]); // [RULE4]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core 4 trim
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			core4_trim_q <= FGT_TRIM_RESET;
		end else if (clk_en) begin
			core4_trim_q <= fgt_trim(regs_q[FGT_IDX_CORE4]); // [RULE6]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core 5 trim
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			core5_trim_q <= FGT_TRIM_RESET;
		end else if (clk_en) begin
			core5_trim_q <= fgt_trim(regs_q[FGT_IDX_CORE5]); // [RULE7]
		end
	end

endmodule

// ---- inc/fgt_pkg.sv ----
// Constants, types and helpers for the fine gain trim register bank
//
// Summary of operation
// RULE1: Register at 0x361 holds five-bit fine gain trim for core 1.
// RULE2: Register at 0x362 trims core 2 while it samples its first input.
// RULE3: Register at 0x363 trims core 2 while it samples its second input.
// RULE4: Register at 0x364 trims core 3 while it samples its first input.
// RULE5: Register at 0x365 trims core 3 while it samples its second input.
// RULE6: Register at 0x366 holds five-bit fine gain trim for core 4.
// RULE7: Register at 0x367 holds five-bit fine gain trim for core 5.
// RULE8: Every trim register loads its default from factory fuse storage.
// RULE9: Software keeps reserved bits 7:5 at zero on every write.
// RULE10: Software reads back every register bit as written or fuse-loaded.
package fgt_pkg;

	////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int FGT_ADDR_W    = 12;
	localparam int FGT_DATA_W    = 8;
	localparam int FGT_TRIM_W    = 5;
	localparam int FGT_NUM_REGS  = 7;
	localparam int FGT_IDX_W     = 3;

	// Trim field position
	localparam int FGT_TRIM_LSB  = 0;
	localparam int FGT_TRIM_MSB  = 4;

	////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [FGT_ADDR_W-1:0] FGT_CORE1_GAIN_TRIM_OFS              = 12'h361;
	localparam logic [FGT_ADDR_W-1:0] FGT_CORE2_FIRST_INPUT_GAIN_TRIM_OFS  = 12'h362;
	localparam logic [FGT_ADDR_W-1:0] FGT_CORE2_SECOND_INPUT_GAIN_TRIM_OFS = 12'h363;
	localparam logic [FGT_ADDR_W-1:0] FGT_CORE3_FIRST_INPUT_GAIN_TRIM_OFS  = 12'h364;
	localparam logic [FGT_ADDR_W-1:0] FGT_CORE3_SECOND_INPUT_GAIN_TRIM_OFS = 12'h365;
	localparam logic [FGT_ADDR_W-1:0] FGT_CORE4_GAIN_TRIM_OFS              = 12'h366;
	localparam logic [FGT_ADDR_W-1:0] FGT_CORE5_GAIN_TRIM_OFS              = 12'h367;

	// Register indices, also fuse word addresses
	localparam logic [FGT_IDX_W-1:0] FGT_IDX_CORE1   = 3'h0;
	localparam logic [FGT_IDX_W-1:0] FGT_IDX_CORE2_A = 3'h1;
	localparam logic [FGT_IDX_W-1:0] FGT_IDX_CORE2_B = 3'h2;
	localparam logic [FGT_IDX_W-1:0] FGT_IDX_CORE3_A = 3'h3;
	localparam logic [FGT_IDX_W-1:0] FGT_IDX_CORE3_B = 3'h4;
	localparam logic [FGT_IDX_W-1:0] FGT_IDX_CORE4   = 3'h5;
	localparam logic [FGT_IDX_W-1:0] FGT_IDX_CORE5   = 3'h6;
	localparam logic [FGT_IDX_W-1:0] FGT_IDX_LAST    = 3'h6;
	localparam logic [FGT_IDX_W-1:0] FGT_IDX_STEP    = 3'h1;

	// Reset values
	localparam logic [FGT_DATA_W-1:0] FGT_REG_RESET  = 8'h00;
	localparam logic [FGT_TRIM_W-1:0] FGT_TRIM_RESET = 5'h00;

	////////////////////////////////////////////////////////////////////////
	// Fuse loader states
	typedef enum logic [1:0] {
		FGT_LD_REQ  = 2'b00,
		FGT_LD_CAPT = 2'b01,
		FGT_LD_DONE = 2'b10
	} fgt_ld_state_type;

	// Register port request
	typedef struct packed {
		logic                  wr;
		logic                  rd;
		logic [FGT_ADDR_W-1:0] addr;
		logic [FGT_DATA_W-1:0] wdata;
	} fgt_bus_req_type;

	// Fuse read request
	typedef struct packed {
		logic                 rd_en;
		logic [FGT_IDX_W-1:0] addr;
	} fgt_fuse_req_type;

	// Loader write into the bank
	typedef struct packed {
		logic                  valid;
		logic [FGT_IDX_W-1:0]  idx;
		logic [FGT_DATA_W-1:0] data;
	} fgt_load_wr_type;

	// Address decode result
	typedef struct packed {
		logic                 hit;
		logic [FGT_IDX_W-1:0] idx;
	} fgt_decode_type;

	////////////////////////////////////////////////////////////////////////
	// Address to register index
	function automatic fgt_decode_type fgt_decode(input logic [FGT_ADDR_W-1:0] addr);
		fgt_decode_type res;
		logic [FGT_ADDR_W-1:0] rel;
		rel     = addr - FGT_CORE1_GAIN_TRIM_OFS;
		res.hit = (addr >= FGT_CORE1_GAIN_TRIM_OFS) && (addr <= FGT_CORE5_GAIN_TRIM_OFS);
		res.idx = rel[FGT_IDX_W-1:0];
		return res;
	endfunction

	// Trim field of a register value
	function automatic logic [FGT_TRIM_W-1:0] fgt_trim(input logic [FGT_DATA_W-1:0] val);
		return val[FGT_TRIM_MSB:FGT_TRIM_LSB];
	endfunction

endpackage

// ---- core/fgt_fuse_loader.sv ----
// Sequencer that copies factory fuse words into the trim bank
`timescale 1ns/1ps
module fgt_fuse_loader
	import fgt_pkg::*;
(
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  reset_n,
	input  wire logic                  clk_en,
	// Control
	input  wire logic                  reload,
	output      logic                  busy,
	// Fuse storage
	output      fgt_fuse_req_type      fuse_req,
	input  wire logic [FGT_DATA_W-1:0] fuse_rd_data,
	// Bank write
	output      fgt_load_wr_type       load_wr_q
);

	fgt_ld_state_type      state_q;
	logic [FGT_IDX_W-1:0]  idx_q;

	////////////////////////////////////////////////////////////////////////
	// Sequence: one read, one capture per word
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= FGT_LD_REQ;
			idx_q   <= FGT_IDX_CORE1;
		end else if (clk_en) begin
			unique case (state_q)
				FGT_LD_REQ: begin
					state_q <= FGT_LD_CAPT;
				end
				FGT_LD_CAPT: begin
					if (idx_q == FGT_IDX_LAST) begin
						state_q <= FGT_LD_DONE;
					end else begin
						idx_q   <= idx_q + FGT_IDX_STEP;
						state_q <= FGT_LD_REQ;
					end
				end
				FGT_LD_DONE: begin
					if (reload) begin
						idx_q   <= FGT_IDX_CORE1;
						state_q <= FGT_LD_REQ;
					end
				end
				default: begin
					state_q <= FGT_LD_DONE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Captured fuse word towards the bank
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			load_wr_q <= '0;
		end else if (clk_en) begin
			load_wr_q.valid <= (state_q == FGT_LD_CAPT); // [RULE8]
			load_wr_q.idx   <= idx_q;
			load_wr_q.data  <= fuse_rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fuse strobe and status
	always_comb begin
		fuse_req.rd_en = (state_q == FGT_LD_REQ) && clk_en;
		fuse_req.addr  = idx_q;
		busy           = (state_q != FGT_LD_DONE);
	end

endmodule

// ---- verification/fgt_regs_monitor.sv ----
// Assertion checker for the fine gain trim bank ports
`timescale 1ns/1ps
module fgt_regs_monitor
	import fgt_pkg::*;
(
	// Clock, reset, register port
	input wire logic                  core_clk,
	input wire logic                  reset_n,
	input wire logic                  clk_en,
	input wire fgt_bus_req_type       bus_req,
	input wire logic [FGT_DATA_W-1:0] rd_data_q,
	// Fuse storage
	input wire fgt_fuse_req_type      fuse_req,
	input wire logic [FGT_DATA_W-1:0] fuse_rd_data,
	input wire logic                  fuse_reload,
	input wire logic                  fuse_busy_q,
	// Trims
	input wire logic                  core2_sel_second,
	input wire logic [FGT_TRIM_W-1:0] core1_trim_q,
	input wire logic [FGT_TRIM_W-1:0] core2_trim_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	wire wr_ok = clk_en && bus_req.wr && !fuse_busy_q && !fuse_reload;
	wire hit = bus_req.addr >= 12'h361 && bus_req.addr <= 12'h367;

	property p_rd_idle;
		clk_en && !bus_req.rd |=> rd_data_q == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not idle");
	property p_wr_rd;
		wr_ok && hit ##1 clk_en && bus_req.rd && bus_req.addr == $past(bus_req.addr)
			|=> rd_data_q == $past(bus_req.wdata, 2);
	endproperty
	a_wr_rd: assert property (p_wr_rd)
		else $error("read back differs from write");
	property p_trim1;
		wr_ok && bus_req.addr == 12'h361 ##1 clk_en
			|=> core1_trim_q == 5'($past(bus_req.wdata, 2));
	endproperty
	a_trim1: assert property (p_trim1)
		else $error("core1 trim wrong");
	property p_trim2b;
		wr_ok && bus_req.addr == 12'h363 ##1 clk_en && core2_sel_second
			|=> core2_trim_q == 5'($past(bus_req.wdata, 2));
	endproperty
	a_trim2b: assert property (p_trim2b)
		else $error("core2 second input trim wrong");
	property p_busy;
		fuse_busy_q |-> ##[0:40] !fuse_busy_q;
	endproperty
	a_busy: assert property (p_busy)
		else $error("fuse load does not end");
	property p_space;
		reset_n && fuse_req.rd_en |=> !fuse_req.rd_en;
	endproperty
	a_space: assert property (p_space)
		else $error("fuse reads too close");
	property p_order;
		reset_n && fuse_req.rd_en && fuse_req.addr != 3'h6 ##1 clk_en [*2]
			|-> fuse_req.rd_en && fuse_req.addr == $past(fuse_req.addr, 2) + 3'h1;
	endproperty
	a_order: assert property (p_order)
		else $error("fuse word order wrong");
	property p_fuse_wr;
		reset_n && fuse_req.rd_en && fuse_req.addr == 3'h0 ##1 clk_en
			##1 clk_en && !bus_req.wr ##1 clk_en
			|=> core1_trim_q == 5'($past(fuse_rd_data, 3));
	endproperty
	a_fuse_wr: assert property (p_fuse_wr)
		else $error("fuse word not loaded");
	c_wr_rd: cover property (wr_ok ##1 bus_req.rd);
	c_load: cover property ($fell(fuse_busy_q));
	c_sel: cover property (clk_en && core2_sel_second);
endmodule

// ---- verification/fgt_regs_tb.sv ----
// Self-checking testbench for the fine gain trim bank
`timescale 1ns/1ps
module fgt_regs_tb;
	import fgt_pkg::*;
	logic                  core_clk = 1'b0;
	logic                  reset_n = 1'b0;
	logic                  clk_en = 1'b1;
	fgt_bus_req_type       bus_req = '0;
	logic [FGT_DATA_W-1:0] rd_data_q;
	fgt_fuse_req_type      fuse_req;
	logic [FGT_DATA_W-1:0] fuse_rd_data = 8'h00;
	logic                  fuse_reload = 1'b0;
	logic                  fuse_busy_q;
	logic                  sel2 = 1'b0;
	logic                  sel3 = 1'b0;
	logic [FGT_TRIM_W-1:0] t1, t2, t3, t4, t5;
	int                    fail_count = 0;
	int                    n_checks = 0;

	always #4 core_clk = ~core_clk;
	fgt_regs i_fgt_regs (.core_clk, .reset_n, .clk_en, .bus_req, .rd_data_q, .fuse_req,
		.fuse_rd_data, .fuse_reload, .fuse_busy_q, .core2_sel_second(sel2),
		.core3_sel_second(sel3), .core1_trim_q(t1), .core2_trim_q(t2),
		.core3_trim_q(t3), .core4_trim_q(t4), .core5_trim_q(t5));

	////////////////////////////////////////////////////////////////////////
	// Fuse storage, toggling outside its answer cycle
	function automatic logic [7:0] fw(input logic [2:0] k);
		return 8'h11 * ({5'h00, k} + 8'h01);
	endfunction
	always @(posedge core_clk) begin
		fuse_rd_data <= fuse_req.rd_en ? fw(fuse_req.addr) : ~fuse_rd_data;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string w, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus_req <= '{1'b1, 1'b0, a, d};
		@(posedge core_clk);
		bus_req <= '0;
		#1;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input string w);
		bus_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge core_clk);
		bus_req <= '0;
		#1 check(w, e, rd_data_q);
	endtask
	task automatic wait_load;
		for (int i = 0; i < 40 && fuse_busy_q !== 1'b0; i++) @(posedge core_clk);
		#1 check("fuse busy", 8'h00, 8'(fuse_busy_q));
	endtask
	task automatic wrap_up;
		$display("checks %0d failures %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_fuse;
		wait_load;
		for (int k = 0; k < 7; k++) rd(12'h361 + 12'(k), fw(3'(k)), "fuse");
		rd(12'h360, 8'h00, "unmapped low");
		check("core5 fuse", 8'h17, 8'(t5));
		$display("test fuse done");
	endtask
	task automatic t_rw;
		sel2 <= 1'b1;
		sel3 <= 1'b1;
		for (int k = 0; k < 7; k++) begin
			wr(12'h361 + 12'(k), 8'h1f - 8'(k));
			rd(12'h361 + 12'(k), 8'h1f - 8'(k), "readback");
		end
		wr(12'h368, 8'h05);
		rd(12'h367, 8'h19, "after unmapped write");
		rd(12'h368, 8'h00, "unmapped high");
		check("core2 b", 8'h1d, 8'(t2));
		check("core3 b", 8'h1b, 8'(t3));
		sel2 <= 1'b0;
		sel3 <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 check("core1", 8'h1f, 8'(t1));
		check("core2 a", 8'h1e, 8'(t2));
		check("core3 a", 8'h1c, 8'(t3));
		check("core4", 8'h1a, 8'(t4));
		check("core5", 8'h19, 8'(t5));
		$display("test rw done");
	endtask
	task automatic t_reload;
		fuse_reload <= 1'b1;
		@(posedge core_clk);
		fuse_reload <= 1'b0;
		repeat (2) @(posedge core_clk);
		wait_load;
		@(posedge core_clk);
		#1 check("core1 fuse", 8'h11, 8'(t1));
		rd(12'h367, 8'h77, "reload");
		$display("test reload done");
	endtask
	task automatic t_freeze;
		clk_en <= 1'b0;
		wr(12'h366, 8'h03);
		clk_en <= 1'b1;
		rd(12'h366, 8'h66, "frozen write");
		$display("test freeze done");
	endtask
	task automatic t_reset;
		wr(12'h366, 8'h0a);
		rd(12'h366, 8'h0a, "before reset");
		reset_n <= 1'b0;
		#1 check("reset read data", 8'h00, rd_data_q);
		repeat (2) @(posedge core_clk);
		#1 check("reset trim", 8'h00, 8'(t4));
		check("reset busy", 8'h01, 8'(fuse_busy_q));
		reset_n <= 1'b1;
		wait_load;
		rd(12'h366, 8'h66, "reset reload");
		check("core4 reload", 8'h06, 8'(t4));
		$display("test reset done");
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		#1;
		t_fuse;
		t_rw;
		t_reload;
		t_freeze;
		t_reset;
		wrap_up;
	end
	initial begin
		#20000;
		fail_count++;
		wrap_up;
	end
endmodule

bind fgt_regs fgt_regs_monitor i_fgt_regs_monitor (.core_clk, .reset_n, .clk_en, .bus_req,
	.rd_data_q, .fuse_req, .fuse_rd_data, .fuse_reload, .fuse_busy_q, .core2_sel_second,
	.core1_trim_q, .core2_trim_q);
